// ### cgr_cfg.svh
`ifndef CGR_CFG_SVH
`define CGR_CFG_SVH

// register indices on the two-wire bus
`define CGR_IDX_CPU_N_HI 8'h04
`define CGR_IDX_CPU_N_LO 8'h05
`define CGR_IDX_LCD_N_HI 8'h08
`define CGR_IDX_LCD_N_LO 8'h09
`define CGR_IDX_REV_MAKER 8'h0b
`define CGR_IDX_PART 8'h0c
`define CGR_IDX_RSV_A 8'h0d
`define CGR_IDX_RSV_B 8'h0e
`define CGR_IDX_RB_LEN 8'h0f
`define CGR_IDX_RSV_FIRST 8'h10
`define CGR_IDX_RSV_LAST 8'h28
`define CGR_IDX_PROG_GATE 8'h29

// field positions
`define CGR_GATE_CPU_BIT 1
`define CGR_GATE_LCD_BIT 0
`define CGR_CPU_N_HI_BIT 0
`define CGR_LCD_N_HI_BIT 7

// fixed and reset values
`define CGR_REV_CODE 4'h0
`define CGR_MAKER_CODE 4'h5 // value is arbitrary
`define CGR_PART_CODE 4'h6 // value is arbitrary
`define CGR_RSV_VALUE 8'h00
`define CGR_CPU_N_HI_RSV 7'h7f
`define CGR_RB_LEN_RESET 6'h0f
`define CGR_DEV_ADDR 7'h69

// per frequency-select cpu divider defaults, panel divider reset value
`define CGR_CPU_N_FS0 9'h0a6
`define CGR_CPU_N_FS1 9'h0c8
`define CGR_CPU_N_FS2 9'h0fa
`define CGR_CPU_N_FS3 9'h12c
`define CGR_LCD_N_RESET 9'h0c8

// cycles after reset release before pin sampling
`define CGR_SETTLE_CYCLES 3'd5

`endif

// ### cgr_pkg.sv
package cgr_pkg;

  // two-wire bus engine states
  typedef enum logic [2:0] {
    CGR_ST_IDLE = 3'b000,
    CGR_ST_ADDR = 3'b001,
    CGR_ST_RX = 3'b010,
    CGR_ST_ACK = 3'b011,
    CGR_ST_TX = 3'b100,
    CGR_ST_TXACK = 3'b101
  } cgr_bus_st_t;

  // clock output behaviour
  typedef enum logic [1:0] {
    CGR_OUT_NORMAL = 2'b00,
    CGR_OUT_HIZ = 2'b01,
    CGR_OUT_REF_DIV = 2'b10
  } cgr_out_mode_t;

endpackage

// ### cgr_test_if.sv
`timescale 1ns/1ps
interface cgr_test_if;
  import cgr_pkg::*;
  logic sel_pin;
  logic mode_pin;
  logic sample;
  cgr_out_mode_t mode;
  logic active;

  modport ctl (input sel_pin, input mode_pin, output sample, output mode, output active);
  modport top (output sel_pin, output mode_pin, input sample, input mode, input active);
endinterface

// ### cgr_sync.sv
`timescale 1ns/1ps
module cgr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pins in, filtered levels out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_s1, next_s2, next_s3, next_clean;

  // a bit changes once stages two and three agree
  always_comb begin
    next_s1 = raw;
    next_s2 = s1;
    next_s3 = s2;
    next_clean = clean;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_clean[i] = s3[i];
      end
    end
  end

  // three-stage synchroniser registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      clean <= RESET_VAL;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      clean <= next_clean;
    end
  end
endmodule

// ### cgr_test_ctl.sv
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module cgr_test_ctl (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // test pins in, output behaviour out
  cgr_test_if.ctl tif
);
  import cgr_pkg::*;

  logic [2:0] settle;
  logic latched;
  logic sample;
  cgr_out_mode_t mode;
  logic [2:0] next_settle;
  logic next_latched;
  logic next_sample;
  cgr_out_mode_t next_mode;

  // one sampling point after power-up, then latch or stay normal
  always_comb begin
    next_settle = settle;
    next_latched = latched;
    next_sample = 1'b0;
    if (settle != `CGR_SETTLE_CYCLES) begin
      next_settle = settle + 3'd1;
      if (next_settle == `CGR_SETTLE_CYCLES) begin
        next_sample = 1'b1;
        next_latched = tif.sel_pin;
      end
    end
    // only reset clears the latch
    if (latched) begin
      next_mode = tif.mode_pin ? CGR_OUT_REF_DIV : CGR_OUT_HIZ;
    end else begin
      next_mode = CGR_OUT_NORMAL;
    end
  end

  // test control registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      settle <= 3'd0;
      latched <= 1'b0;
      sample <= 1'b0;
      mode <= CGR_OUT_NORMAL;
    end else begin
      settle <= next_settle;
      latched <= next_latched;
      sample <= next_sample;
      mode <= next_mode;
    end
  end

  assign tif.sample = sample;
  assign tif.mode = mode;
  assign tif.active = latched;
endmodule

// ### cgr_regbank.sv
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module cgr_regbank #(
  parameter logic [6:0] DEV_ADDR = `CGR_DEV_ADDR,
  parameter logic [3:0] MAKER_CODE = `CGR_MAKER_CODE,
  parameter logic [3:0] PART_CODE = `CGR_PART_CODE
) (
  // clock and power-up reset
  input wire logic clock,
  input wire logic nrst,
  // two-wire bus pins
  input wire logic sclk_in,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe_n,
  // test and frequency strap pins
  input wire logic test_sel,
  input wire logic test_mode,
  input wire logic [1:0] freq_sel,
  // clock output control
  output cgr_pkg::cgr_out_mode_t out_mode,
  output logic test_active,
  output logic [8:0] cpu_n_div,
  output logic [8:0] lcd_n_div
);
  import cgr_pkg::*;

  // fs-dependent cpu divider default
  function automatic logic [8:0] cpu_n_default(input logic [1:0] fs);
    case (fs)
      2'h0: cpu_n_default = `CGR_CPU_N_FS0;
      2'h1: cpu_n_default = `CGR_CPU_N_FS1;
      2'h2: cpu_n_default = `CGR_CPU_N_FS2;
      default: cpu_n_default = `CGR_CPU_N_FS3;
    endcase
  endfunction

  logic scl, sda;
  logic [1:0] fs;
  cgr_test_if tif ();

  // bus pins, idle high
  cgr_sync #(
    .W(2),
    .RESET_VAL(2'h3)
  ) u_bus_sync (
    .clock(clock),
    .nrst(nrst),
    .raw({sclk_in, sdata_in}),
    .clean({scl, sda})
  );

  // strap and test pins
  cgr_sync #(
    .W(4),
    .RESET_VAL(4'h0)
  ) u_pin_sync (
    .clock(clock),
    .nrst(nrst),
    .raw({freq_sel, test_sel, test_mode}),
    .clean({fs, tif.sel_pin, tif.mode_pin})
  );

  cgr_test_ctl u_test (
    .clock(clock),
    .nrst(nrst),
    .tif(tif)
  );

  assign out_mode = tif.mode;
  assign test_active = tif.active;

  // bus engine state
  cgr_bus_st_t st, next_st;
  logic scl_q, sda_q;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] index, next_index;
  logic [1:0] role, next_role;
  logic [5:0] remain, next_remain;
  logic rd_mode, next_rd_mode;
  logic acked, next_acked;
  logic drive, next_drive;
  logic wr_en;
  logic [7:0] rd_val;

  // configuration state
  logic [8:0] cpu_n_prog, next_cpu_n_prog;
  logic [8:0] lcd_n_prog, next_lcd_n_prog;
  logic [5:0] rb_len, next_rb_len;
  logic gate_cpu, next_gate_cpu;
  logic gate_lcd, next_gate_lcd;
  logic [8:0] next_cpu_n_div, next_lcd_n_div;

  // bus conditions from filtered pins
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda;
  assign bus_stop = scl & scl_q & ~sda_q & sda;

  // read data mux by index
  always_comb begin
    case (index)
      `CGR_IDX_CPU_N_HI: rd_val = {`CGR_CPU_N_HI_RSV, cpu_n_prog[8]};
      `CGR_IDX_CPU_N_LO: rd_val = cpu_n_prog[7:0];
      `CGR_IDX_LCD_N_HI: rd_val = {lcd_n_prog[8], 7'h00};
      `CGR_IDX_LCD_N_LO: rd_val = lcd_n_prog[7:0];
      `CGR_IDX_REV_MAKER: rd_val = {`CGR_REV_CODE, MAKER_CODE};
      `CGR_IDX_PART: rd_val = {PART_CODE, 4'h0};
      `CGR_IDX_RSV_A: rd_val = `CGR_RSV_VALUE;
      `CGR_IDX_RSV_B: rd_val = `CGR_RSV_VALUE;
      `CGR_IDX_RB_LEN: rd_val = {2'h0, rb_len};
      `CGR_IDX_PROG_GATE: rd_val = {6'h00, gate_cpu, gate_lcd};
      default: rd_val = `CGR_RSV_VALUE;
    endcase
  end

  // bus engine next state
  always_comb begin
    next_st = st;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_index = index;
    next_role = role;
    next_remain = remain;
    next_rd_mode = rd_mode;
    next_acked = acked;
    next_drive = drive;
    wr_en = 1'b0;
    if (bus_start) begin
      next_st = CGR_ST_ADDR;
      next_bitcnt = 4'h0;
      next_drive = 1'b0;
    end else if (bus_stop) begin
      next_st = CGR_ST_IDLE;
      next_drive = 1'b0;
    end else begin
      case (st)
        CGR_ST_ADDR, CGR_ST_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            if (st == CGR_ST_ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin
                next_drive = 1'b1;
                next_rd_mode = shreg[0];
                next_role = 2'h0;
                next_st = CGR_ST_ACK;
              end else begin
                next_st = CGR_ST_IDLE;
              end
            end else begin
              next_drive = 1'b1;
              next_st = CGR_ST_ACK;
              case (role)
                2'h0: begin
                  next_index = shreg;
                  next_role = 2'h1;
                end
                2'h1: next_role = 2'h2; // host count byte
                default: begin
                  wr_en = 1'b1;
                  next_index = index + 8'h01;
                end
              endcase
            end
          end
        end
        CGR_ST_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (rd_mode) begin
              next_shreg = {2'h0, rb_len};
              next_remain = rb_len;
              next_drive = 1'b1;
              next_st = CGR_ST_TX;
            end else begin
              next_drive = 1'b0;
              next_st = CGR_ST_RX;
            end
          end
        end
        CGR_ST_TX: begin
          next_drive = ~shreg[7];
          if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              next_drive = 1'b0;
              next_st = CGR_ST_TXACK;
            end else begin
              next_drive = ~shreg[6];
            end
          end
        end
        CGR_ST_TXACK: begin
          if (scl_rise) begin
            next_acked = ~sda;
          end else if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (acked && remain != 6'h00) begin
              next_shreg = rd_val;
              next_index = index + 8'h01;
              next_remain = remain - 6'h01;
              next_drive = ~rd_val[7];
              next_st = CGR_ST_TX;
            end else begin
              next_st = CGR_ST_IDLE; // count sent, or host did not acknowledge
            end
          end
        end
        default: next_st = CGR_ST_IDLE;
      endcase
    end
  end

  // bus engine registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= CGR_ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      index <= 8'h00;
      role <= 2'h0;
      remain <= 6'h00;
      rd_mode <= 1'b0;
      acked <= 1'b0;
      drive <= 1'b0;
    end else begin
      st <= next_st;
      scl_q <= scl;
      sda_q <= sda;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      index <= next_index;
      role <= next_role;
      remain <= next_remain;
      rd_mode <= next_rd_mode;
      acked <= next_acked;
      drive <= next_drive;
    end
  end

  // open-drain data line, only ever pulls low
  assign sdata_out = 1'b0;
  assign sdata_oe_n = ~drive;

  // register writes, strap defaults and gated divider transfer
  always_comb begin
    next_cpu_n_prog = cpu_n_prog;
    next_lcd_n_prog = lcd_n_prog;
    next_rb_len = rb_len;
    next_gate_cpu = gate_cpu;
    next_gate_lcd = gate_lcd;
    next_cpu_n_div = cpu_n_div;
    next_lcd_n_div = lcd_n_div;
    if (tif.sample) begin
      next_cpu_n_prog = cpu_n_default(fs);
      next_cpu_n_div = cpu_n_default(fs);
    end else if (wr_en) begin
      case (index)
        `CGR_IDX_CPU_N_HI: next_cpu_n_prog[8] = shreg[`CGR_CPU_N_HI_BIT];
        `CGR_IDX_CPU_N_LO: next_cpu_n_prog[7:0] = shreg;
        `CGR_IDX_LCD_N_HI: next_lcd_n_prog[8] = shreg[`CGR_LCD_N_HI_BIT];
        `CGR_IDX_LCD_N_LO: next_lcd_n_prog[7:0] = shreg;
        `CGR_IDX_RB_LEN: next_rb_len = shreg[5:0];
        `CGR_IDX_PROG_GATE: begin
          next_gate_cpu = shreg[`CGR_GATE_CPU_BIT];
          next_gate_lcd = shreg[`CGR_GATE_LCD_BIT];
        end
        default: next_rb_len = rb_len; // read-only and reserved
      endcase
    end
    // programmed value reaches the divider only while gated open
    if (gate_cpu) begin
      next_cpu_n_div = cpu_n_prog;
    end
    if (gate_lcd) begin
      next_lcd_n_div = lcd_n_prog;
    end
  end

  // configuration registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpu_n_prog <= `CGR_CPU_N_FS0;
      lcd_n_prog <= `CGR_LCD_N_RESET;
      rb_len <= `CGR_RB_LEN_RESET;
      gate_cpu <= 1'b0;
      gate_lcd <= 1'b0;
      cpu_n_div <= `CGR_CPU_N_FS0;
      lcd_n_div <= `CGR_LCD_N_RESET;
    end else begin
      cpu_n_prog <= next_cpu_n_prog;
      lcd_n_prog <= next_lcd_n_prog;
      rb_len <= next_rb_len;
      gate_cpu <= next_gate_cpu;
      gate_lcd <= next_gate_lcd;
      cpu_n_div <= next_cpu_n_div;
      lcd_n_div <= next_lcd_n_div;
    end
  end
endmodule

// ### cgr_regbank_properties.sv
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module cgr_regbank_properties (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched pins
  input wire logic sclk_in,
  input wire logic sdata_oe_n,
  input wire logic [1:0] freq_sel,
  input wire logic test_mode,
  input wire cgr_pkg::cgr_out_mode_t out_mode,
  input wire logic test_active,
  input wire logic [8:0] cpu_n_div,
  input wire logic [8:0] lcd_n_div
);
  import cgr_pkg::*;
  logic [3:0] since_rel;
  logic [3:0] next_since_rel;
  // cycles since reset release, saturating
  always_comb begin
    next_since_rel = since_rel;
    if (since_rel != 4'hf) next_since_rel = since_rel + 4'h1;
    if (!nrst) next_since_rel = 4'h0;
  end
  always_ff @(posedge clock) begin
    since_rel <= next_since_rel;
  end
  // strap table of the cpu divider
  function automatic logic [8:0] fs_n(input logic [1:0] fs);
    case (fs)
      2'h0: fs_n = `CGR_CPU_N_FS0;
      2'h1: fs_n = `CGR_CPU_N_FS1;
      2'h2: fs_n = `CGR_CPU_N_FS2;
      default: fs_n = `CGR_CPU_N_FS3;
    endcase
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // reset leaves bus released and outputs normal
  property p_rst; $rose(nrst) |-> sdata_oe_n && out_mode == CGR_OUT_NORMAL && !test_active; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_lcd_rst; $rose(nrst) |-> lcd_n_div == `CGR_LCD_N_RESET; endproperty
  a_lcd_rst: assert property (p_lcd_rst) else $error("panel divider reset wrong");
  property p_cpu_strap; $rose(nrst) |-> ##8 cpu_n_div == fs_n(freq_sel); endproperty
  a_cpu_strap: assert property (p_cpu_strap) else $error("cpu divider strap wrong");
  property p_latch_early; $rose(test_active) |-> since_rel < 4'ha; endproperty
  a_latch_early: assert property (p_latch_early) else $error("test latched late");
  property p_sticky; test_active |=> test_active; endproperty
  a_sticky: assert property (p_sticky) else $error("test mode left");
  property p_normal; !test_active |-> out_mode == CGR_OUT_NORMAL; endproperty
  a_normal: assert property (p_normal) else $error("outputs not normal");
  // latched test mode follows the mode pin once the pin has settled
  property p_hiz; (test_active && !test_mode) [*7] |-> out_mode == CGR_OUT_HIZ; endproperty
  a_hiz: assert property (p_hiz) else $error("test outputs not high impedance");
  property p_ref; (test_active && test_mode) [*7] |-> out_mode == CGR_OUT_REF_DIV; endproperty
  a_ref: assert property (p_ref) else $error("test outputs not reference divided");
  // data line only moves while the bus clock is low
  property p_ack_hold; sclk_in [*6] |-> $stable(sdata_oe_n); endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data line moved while bus clock high");
endmodule

bind cgr_regbank cgr_regbank_properties i_props (
  .clock(clock),
  .nrst(nrst),
  .sclk_in(sclk_in),
  .sdata_oe_n(sdata_oe_n),
  .freq_sel(freq_sel),
  .test_mode(test_mode),
  .out_mode(out_mode),
  .test_active(test_active),
  .cpu_n_div(cpu_n_div),
  .lcd_n_div(lcd_n_div)
);

// ### cgr_host.sv
`timescale 1ns/1ps
module cgr_host #(
  parameter logic [6:0] ADDR = 7'h69
) (
  // clock
  input wire logic clock,
  // wired data level in, clock and data release out
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  logic [7:0] rb [0:65];
  logic nak;
  // bus idle, lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nak = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit slot: data moves mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    sda_drv <= b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic start_c;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_drv <= 1'b0;
    tick(8);
    scl <= 1'b0;
  endtask
  task automatic stop_c;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_drv <= 1'b1;
    tick(8);
  endtask
  // byte out, msb first, then the device acknowledge
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    nak = nak | r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d);
    nak = 1'b0;
    start_c;
    put({a, 1'b0});
    put(idx);
    put(8'h01);
    put(d);
    stop_c;
  endtask
  // block read: count byte, count data bytes, one byte beyond
  task automatic rd(input logic [7:0] idx);
    logic [7:0] n;
    nak = 1'b0;
    start_c;
    put({ADDR, 1'b0});
    put(idx);
    start_c;
    put({ADDR, 1'b1});
    get(1'b0, n);
    rb[0] = n;
    // data only reported, never reused
    for (int i = 1; i <= n + 1; i++) get(i == n + 1, rb[i]);
    stop_c;
  endtask
endmodule

// ### cgr_regbank_tb.sv
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module cgr_regbank_tb;
  import cgr_pkg::*;
  localparam logic [6:0] ADDR = `CGR_DEV_ADDR;
  localparam logic [3:0] MAKER = 4'ha; // arbitrary
  localparam logic [3:0] PART = 4'h9; // arbitrary
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic test_sel = 1'b0;
  logic test_mode = 1'b0;
  logic [1:0] freq_sel = 2'h2;
  logic scl;
  logic sda_drv;
  logic sdata_out;
  logic sdata_oe_n;
  cgr_out_mode_t out_mode;
  logic test_active;
  logic [8:0] cpu_n_div;
  logic [8:0] lcd_n_div;
  logic [8:0] fs_tab [4] = '{`CGR_CPU_N_FS0, `CGR_CPU_N_FS1, `CGR_CPU_N_FS2, `CGR_CPU_N_FS3};
  int fail_count = 0;
  int n_compared = 0;
  // open-drain data wire with pull-up
  wire sda = sda_drv & (sdata_oe_n | sdata_out);
  always #4 clock = ~clock;
  cgr_regbank #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (.clock(clock), .nrst(nrst), .sclk_in(scl),
    .sdata_in(sda), .sdata_out(sdata_out), .sdata_oe_n(sdata_oe_n), .test_sel(test_sel), .test_mode(test_mode),
    .freq_sel(freq_sel), .out_mode(out_mode), .test_active(test_active), .cpu_n_div(cpu_n_div), .lcd_n_div(lcd_n_div));
  cgr_host #(.ADDR(ADDR)) i_host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic power_up(input logic sel);
    nrst <= 1'b0;
    test_sel <= sel;
    tick(3);
    nrst <= 1'b1;
    tick(12);
  endtask
  // normal strap: the mode pin has no effect
  task automatic t_normal;
    test_mode <= 1'b1;
    tick(12);
    chk(test_active, 0);
    chk(out_mode, CGR_OUT_NORMAL);
    chk(cpu_n_div, `CGR_CPU_N_FS2);
    chk(lcd_n_div, `CGR_LCD_N_RESET);
  endtask
  // identity, reserved bytes and default length
  task automatic t_ids;
    i_host.rd(8'h0b);
    chk(i_host.nak, 0);
    chk(i_host.rb[0], 8'h0f);
    chk(i_host.rb[1], {4'h0, MAKER});
    chk(i_host.rb[2], {PART, 4'h0});
    chk(i_host.rb[3], 8'h00);
    chk(i_host.rb[4], 8'h00);
    chk(i_host.rb[5], 8'h0f);
    for (int i = 6; i <= 15; i++) chk(i_host.rb[i], 8'h00);
    chk(i_host.rb[16], 8'hff);
  endtask
  // writes to read-only and reserved places, then a short length
  task automatic t_len;
    i_host.wr(ADDR, 8'h0b, 8'hff);
    i_host.wr(ADDR, 8'h0d, 8'ha5);
    i_host.wr(ADDR, 8'h14, 8'h5a);
    i_host.wr(ADDR, 8'h0f, 8'hc3);
    chk(i_host.nak, 0);
    i_host.rd(8'h0b);
    chk(i_host.rb[0], 8'h03);
    chk(i_host.rb[1], {4'h0, MAKER});
    chk(i_host.rb[2], {PART, 4'h0});
    chk(i_host.rb[3], 8'h00);
    chk(i_host.rb[4], 8'hff);
    for (int k = 0; k < 2; k++) begin
      i_host.rd(k ? 8'h26 : 8'h12);
      for (int j = 1; j <= 3; j++) chk(i_host.rb[j], 8'h00);
      chk(i_host.rb[4], 8'hff);
    end
  endtask
  // divider values pass only while their gate bit is set
  task automatic t_gate;
    i_host.wr(ADDR, 8'h04, 8'h01);
    i_host.wr(ADDR, 8'h05, 8'h23);
    i_host.wr(ADDR, 8'h08, 8'h80);
    i_host.wr(ADDR, 8'h09, 8'h45);
    chk(cpu_n_div, `CGR_CPU_N_FS2);
    chk(lcd_n_div, `CGR_LCD_N_RESET);
    i_host.wr(ADDR, 8'h29, 8'h02);
    tick(4);
    chk(cpu_n_div, 9'h123);
    chk(lcd_n_div, `CGR_LCD_N_RESET);
    i_host.wr(ADDR, 8'h29, 8'h01);
    i_host.wr(ADDR, 8'h05, 8'h77);
    tick(4);
    chk(cpu_n_div, 9'h123);
    chk(lcd_n_div, 9'h145);
    i_host.wr(7'h12, 8'h29, 8'h00);
    chk(i_host.nak, 1);
    i_host.rd(8'h29);
    chk(i_host.rb[1], 8'h01);
    i_host.rd(8'h04);
    chk(i_host.rb[1], 8'hff);
    chk(i_host.rb[2], 8'h77);
  endtask
  // test latch at power-up, pin follow, power cycle to leave
  task automatic t_test;
    test_mode <= 1'b0;
    power_up(1'b1);
    chk(test_active, 1);
    chk(out_mode, CGR_OUT_HIZ);
    test_mode <= 1'b1;
    test_sel <= 1'b0;
    tick(12);
    chk(out_mode, CGR_OUT_REF_DIV);
    i_host.wr(ADDR, 8'h29, 8'h00);
    chk(test_active, 1);
    chk(out_mode, CGR_OUT_REF_DIV);
    for (int f = 0; f < 4; f++) begin
      freq_sel <= f[1:0];
      power_up(1'b0);
      chk(test_active, 0);
      chk(out_mode, CGR_OUT_NORMAL);
      chk(cpu_n_div, fs_tab[f]);
    end
  endtask
  initial begin
    power_up(1'b0);
    t_normal;
    t_ids;
    t_len;
    t_gate;
    t_test;
    test_done;
  end
  // watchdog against a hung bus
  initial begin
    tick(80000);
    fail_count++;
    test_done;
  end
endmodule
